/* File: hw/sbc_pkg.sv */
`default_nettype none
package sbc_pkg;
   // register byte addresses
   localparam logic [6:0] ADDR_CARRIER_HIGH = 7'h07;
   localparam logic [6:0] ADDR_CARRIER_MID = 7'h08;
   localparam logic [6:0] ADDR_CARRIER_LOW = 7'h09;
   localparam logic [6:0] ADDR_RATE_HIGH = 7'h03;
   localparam logic [6:0] ADDR_RATE_LOW = 7'h04;
   localparam logic [6:0] ADDR_PIN_MAP = 7'h25;
   localparam logic [6:0] ADDR_PIN_MAP2 = 7'h26;
   localparam logic [6:0] ADDR_BATTERY = 7'h0C;
   localparam logic [6:0] ADDR_CONTROL = 7'h01;
   localparam logic [6:0] ADDR_STATUS = 7'h27;
   localparam logic [6:0] ADDR_REF_SELECT = 7'h59;
   // field positions
   localparam int REF_EXT_BIT = 4;
   localparam int CTRL_SEQ_BIT = 7;
   localparam int CTRL_CONT_BIT = 6;
   localparam int CTRL_SHAPE_BIT = 5;
   localparam int CTRL_TX_BIT = 4;
   localparam int CTRL_MODE_LSB = 2;
   // reset values
   localparam logic [23:0] CARRIER_RESET = 24'h6C8000;
   localparam logic [15:0] RATE_RESET = 16'h1A0B;
   localparam logic [7:0] PIN_MAP_RESET = 8'h00;
   localparam logic [7:0] PIN_MAP2_RESET = 8'h00;
   localparam logic [7:0] BATTERY_RESET = 8'h02;
   localparam logic [7:0] CONTROL_RESET = 8'h84;
   localparam logic [7:0] REF_SELECT_RESET = 8'h09;
   // timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int OSC_SETTLE_US = 250;
   localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_US * 1000) / CLK_PERIOD_NS;
   localparam int SYNTH_LOCK_US = 80;
   localparam int SYNTH_LOCK_CYCLES = (SYNTH_LOCK_US * 1000) / CLK_PERIOD_NS;
   localparam int CAL_COARSE_CYCLES = 64;
   localparam int CAL_FINE_CYCLES = 16;
   localparam int STEP_RESOLUTION_BITS = 19;
   // operating modes
   localparam logic [1:0] MODE_SLEEP = 2'h0;

   typedef struct packed {
      logic write;
      logic [6:0] addr;
      logic [7:0] data;
   } sbc_reg_req_s;

   typedef struct packed {
      logic rx_enable;
      logic tx_enable;
      logic pll_enable;
   } sbc_radio_en_s;

   typedef enum logic [2:0] {
      SBC_WAIT_OSC,
      SBC_COARSE_CAL,
      SBC_IDLE,
      SBC_FINE_CAL,
      SBC_WAIT_LOCK,
      SBC_ACTIVE
   } sbc_seq_e;
endpackage : sbc_pkg
`default_nettype wire

/* File: hw/sbc_synth_bit_rate_divisor_field.sv */
`default_nettype none
module sbc_synth_bit_rate_divisor_field #(
   parameter int OSC_SETTLE = sbc_pkg::OSC_SETTLE_CYCLES,
   parameter int SYNTH_LOCK = sbc_pkg::SYNTH_LOCK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire sbc_pkg::sbc_reg_req_s reg_req,
   input wire logic reg_req_valid,
   output logic [7:0] reg_rdata,
   input wire logic osc_stable_raw,
   input wire logic battery_below_raw,
   input wire logic pll_lock_raw,
   input wire logic serial_data_pin,
   output logic [23:0] synth_word,
   output logic synth_word_load,
   output logic ref_external,
   output logic coarse_cal_run,
   output logic fine_cal_run,
   output sbc_pkg::sbc_radio_en_s radio_en,
   output logic tx_data_bit,
   output logic general_pin_five,
   output logic [3:0] general_pins,
   output logic bit_clock_pin
);
   logic [23:0] carrier_frequency_reg;
   logic [7:0] carrier_high_shadow;
   logic [7:0] carrier_mid_shadow;
   logic [15:0] bit_rate_reg;
   logic [7:0] pin_event_map_reg;
   logic [7:0] pin_map_second_reg;
   logic [7:0] battery_threshold_reg;
   logic [7:0] control_reg;
   logic [7:0] ref_select_reg;
   logic [2:0] osc_sync;
   logic [2:0] batt_sync;
   logic [2:0] lock_sync;
   logic [2:0] data_sync;
   logic osc_ok;
   logic batt_low;
   logic pll_locked;
   logic data_in;
   logic [31:0] wait_cnt;
   logic [31:0] next_wait_cnt;
   sbc_pkg::sbc_seq_e seq_state;
   sbc_pkg::sbc_seq_e next_seq_state;
   logic [15:0] rate_cnt;
   logic bit_tick;
   logic [2:0] clk_div;
   logic clk_out_level;

   wire wr = reg_req_valid & reg_req.write;
   wire wr_high = wr & (reg_req.addr == sbc_pkg::ADDR_CARRIER_HIGH);
   wire wr_mid = wr & (reg_req.addr == sbc_pkg::ADDR_CARRIER_MID);
   wire wr_low = wr & (reg_req.addr == sbc_pkg::ADDR_CARRIER_LOW);
   wire wr_rate_h = wr & (reg_req.addr == sbc_pkg::ADDR_RATE_HIGH);
   wire wr_rate_l = wr & (reg_req.addr == sbc_pkg::ADDR_RATE_LOW);
   wire wr_map = wr & (reg_req.addr == sbc_pkg::ADDR_PIN_MAP);
   wire wr_map2 = wr & (reg_req.addr == sbc_pkg::ADDR_PIN_MAP2);
   wire wr_batt = wr & (reg_req.addr == sbc_pkg::ADDR_BATTERY);
   wire wr_ctrl = wr & (reg_req.addr == sbc_pkg::ADDR_CONTROL);
   wire wr_ref = wr & (reg_req.addr == sbc_pkg::ADDR_REF_SELECT);
   wire seq_on = control_reg[sbc_pkg::CTRL_SEQ_BIT];
   wire cont_mode = control_reg[sbc_pkg::CTRL_CONT_BIT];
   wire shaping = control_reg[sbc_pkg::CTRL_SHAPE_BIT];
   wire want_tx = control_reg[sbc_pkg::CTRL_TX_BIT];
   wire [1:0] op_mode = control_reg[sbc_pkg::CTRL_MODE_LSB +: 2];
   wire radio_req = seq_on & (op_mode != sbc_pkg::MODE_SLEEP);
   wire [2:0] clk_sel = pin_map_second_reg[2:0];
   wire clk_off = (clk_sel == 3'h7) | (op_mode == sbc_pkg::MODE_SLEEP);
   wire rate_timed = ~cont_mode | shaping;
   wire [15:0] rate_div = (bit_rate_reg == 16'h0000) ? 16'h0001 : bit_rate_reg;
   wire [23:0] commit_word = {carrier_high_shadow, carrier_mid_shadow, reg_req.data};
   wire [7:0] status_byte = {4'h0, batt_low, pll_locked, osc_ok, seq_state == sbc_pkg::SBC_ACTIVE};
   // lock indicator and battery event routing
   wire [1:0] batt_pin_sel = pin_event_map_reg[1:0];
   wire [1:0] lock_pin_sel = pin_event_map_reg[3:2];
   wire [3:0] next_general_pins;

   // three stage input capture
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_sync <= 3'h0;
         batt_sync <= 3'h0;
         lock_sync <= 3'h0;
         data_sync <= 3'h0;
         osc_ok <= 1'b0;
         batt_low <= 1'b0;
         pll_locked <= 1'b0;
         data_in <= 1'b0;
      end else begin
         osc_sync <= {osc_sync[1:0], osc_stable_raw};
         batt_sync <= {batt_sync[1:0], battery_below_raw};
         lock_sync <= {lock_sync[1:0], pll_lock_raw};
         data_sync <= {data_sync[1:0], serial_data_pin};
         if (osc_sync[1] == osc_sync[2]) osc_ok <= osc_sync[2];
         if (batt_sync[1] == batt_sync[2]) batt_low <= batt_sync[2];
         if (lock_sync[1] == lock_sync[2]) pll_locked <= lock_sync[2];
         if (data_sync[1] == data_sync[2]) data_in <= data_sync[2];
      end
   end

   // register file
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         carrier_high_shadow <= sbc_pkg::CARRIER_RESET[23:16];
         carrier_mid_shadow <= sbc_pkg::CARRIER_RESET[15:8];
         carrier_frequency_reg <= sbc_pkg::CARRIER_RESET;
         bit_rate_reg <= sbc_pkg::RATE_RESET;
         pin_event_map_reg <= sbc_pkg::PIN_MAP_RESET;
         pin_map_second_reg <= sbc_pkg::PIN_MAP2_RESET;
         battery_threshold_reg <= sbc_pkg::BATTERY_RESET;
         control_reg <= sbc_pkg::CONTROL_RESET;
         ref_select_reg <= sbc_pkg::REF_SELECT_RESET;
      end else begin
         if (wr_high) carrier_high_shadow <= reg_req.data;
         if (wr_mid) carrier_mid_shadow <= reg_req.data;
         if (wr_low) carrier_frequency_reg <= commit_word;
         if (wr_rate_h) bit_rate_reg[15:8] <= reg_req.data;
         if (wr_rate_l) bit_rate_reg[7:0] <= reg_req.data;
         if (wr_map) pin_event_map_reg <= reg_req.data;
         if (wr_map2) pin_map_second_reg <= reg_req.data;
         if (wr_batt) battery_threshold_reg <= reg_req.data;
         if (wr_ctrl) control_reg <= reg_req.data;
         if (wr_ref) ref_select_reg <= reg_req.data;
      end
   end

   // read mux
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      case (reg_req.addr)
         sbc_pkg::ADDR_CARRIER_HIGH: next_rdata = carrier_high_shadow;
         sbc_pkg::ADDR_CARRIER_MID: next_rdata = carrier_mid_shadow;
         sbc_pkg::ADDR_CARRIER_LOW: next_rdata = carrier_frequency_reg[7:0];
         sbc_pkg::ADDR_RATE_HIGH: next_rdata = bit_rate_reg[15:8];
         sbc_pkg::ADDR_RATE_LOW: next_rdata = bit_rate_reg[7:0];
         sbc_pkg::ADDR_PIN_MAP: next_rdata = pin_event_map_reg;
         sbc_pkg::ADDR_PIN_MAP2: next_rdata = pin_map_second_reg;
         sbc_pkg::ADDR_BATTERY: next_rdata = battery_threshold_reg;
         sbc_pkg::ADDR_CONTROL: next_rdata = control_reg;
         sbc_pkg::ADDR_STATUS: next_rdata = status_byte;
         sbc_pkg::ADDR_REF_SELECT: next_rdata = ref_select_reg;
         default: next_rdata = 8'h00;
      endcase
   end

   // start-up sequencer
   always_comb begin
      next_seq_state = seq_state;
      next_wait_cnt = wait_cnt;
      case (seq_state)
         sbc_pkg::SBC_WAIT_OSC: begin
            if (osc_ok || wait_cnt >= 32'(OSC_SETTLE)) begin
               next_seq_state = sbc_pkg::SBC_COARSE_CAL;
               next_wait_cnt = 32'h0;
            end else begin
               next_wait_cnt = wait_cnt + 32'h1;
            end
         end
         sbc_pkg::SBC_COARSE_CAL: begin
            if (wait_cnt >= 32'(sbc_pkg::CAL_COARSE_CYCLES - 1)) begin
               next_seq_state = sbc_pkg::SBC_IDLE;
               next_wait_cnt = 32'h0;
            end else begin
               next_wait_cnt = wait_cnt + 32'h1;
            end
         end
         sbc_pkg::SBC_IDLE: begin
            next_wait_cnt = 32'h0;
            if (radio_req) next_seq_state = sbc_pkg::SBC_FINE_CAL;
         end
         sbc_pkg::SBC_FINE_CAL: begin
            if (!radio_req) begin
               next_seq_state = sbc_pkg::SBC_IDLE;
            end else if (wait_cnt >= 32'(sbc_pkg::CAL_FINE_CYCLES - 1)) begin
               next_seq_state = sbc_pkg::SBC_WAIT_LOCK;
               next_wait_cnt = 32'h0;
            end else begin
               next_wait_cnt = wait_cnt + 32'h1;
            end
         end
         sbc_pkg::SBC_WAIT_LOCK: begin
            if (!radio_req) begin
               next_seq_state = sbc_pkg::SBC_IDLE;
            end else if (pll_locked || wait_cnt >= 32'(SYNTH_LOCK)) begin
               next_seq_state = sbc_pkg::SBC_ACTIVE;
            end else begin
               next_wait_cnt = wait_cnt + 32'h1;
            end
         end
         sbc_pkg::SBC_ACTIVE: begin
            if (!radio_req) next_seq_state = sbc_pkg::SBC_IDLE;
         end
         default: next_seq_state = sbc_pkg::SBC_WAIT_OSC;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         seq_state <= sbc_pkg::SBC_WAIT_OSC;
         wait_cnt <= 32'h0;
      end else begin
         seq_state <= next_seq_state;
         wait_cnt <= next_wait_cnt;
      end
   end

   // bit rate divider, one tick per bit
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rate_cnt <= 16'h0000;
         bit_tick <= 1'b0;
      end else if (!rate_timed || seq_state != sbc_pkg::SBC_ACTIVE) begin
         rate_cnt <= 16'h0000;
         bit_tick <= 1'b0;
      end else if (rate_cnt >= rate_div - 16'h0001) begin
         rate_cnt <= 16'h0000;
         bit_tick <= 1'b1;
      end else begin
         rate_cnt <= rate_cnt + 16'h0001;
         bit_tick <= 1'b0;
      end
   end

   // reference clock divider
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_div <= 3'h0;
      end else begin
         clk_div <= clk_div + 3'h1;
      end
   end

   always_comb begin
      clk_out_level = 1'b0;
      case (clk_sel)
         3'h0: clk_out_level = 1'b1;
         3'h1: clk_out_level = clk_div[0];
         3'h2: clk_out_level = clk_div[1];
         3'h3: clk_out_level = clk_div[2];
         default: clk_out_level = 1'b0;
      endcase
   end

   // per pin event routing
   for (genvar p = 0; p < 4; p++) begin : g_pin_route
      assign next_general_pins[p] = ((batt_pin_sel == 2'(p)) & batt_low) |
         ((lock_pin_sel == 2'(p)) & pll_locked);
   end

   // registered outputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
         synth_word <= sbc_pkg::CARRIER_RESET;
         synth_word_load <= 1'b0;
         ref_external <= 1'b0;
         coarse_cal_run <= 1'b0;
         fine_cal_run <= 1'b0;
         radio_en <= '0;
         tx_data_bit <= 1'b0;
         general_pin_five <= 1'b0;
         general_pins <= 4'h0;
         bit_clock_pin <= 1'b0;
      end else begin
         reg_rdata <= next_rdata;
         synth_word <= wr_low ? commit_word : carrier_frequency_reg;
         synth_word_load <= wr_low;
         ref_external <= ref_select_reg[sbc_pkg::REF_EXT_BIT];
         coarse_cal_run <= (seq_state == sbc_pkg::SBC_COARSE_CAL);
         fine_cal_run <= (seq_state == sbc_pkg::SBC_FINE_CAL);
         radio_en.pll_enable <= (seq_state == sbc_pkg::SBC_FINE_CAL) |
            (seq_state == sbc_pkg::SBC_WAIT_LOCK) | (seq_state == sbc_pkg::SBC_ACTIVE);
         radio_en.tx_enable <= (seq_state == sbc_pkg::SBC_ACTIVE) & want_tx;
         radio_en.rx_enable <= (seq_state == sbc_pkg::SBC_ACTIVE) & ~want_tx;
         if (!cont_mode || !shaping || bit_tick) tx_data_bit <= data_in;
         general_pin_five <= osc_ok & ~clk_off & clk_out_level;
         general_pins <= next_general_pins;
         bit_clock_pin <= bit_tick & cont_mode & shaping & (seq_state == sbc_pkg::SBC_ACTIVE);
      end
   end
endmodule : sbc_synth_bit_rate_divisor_field
`default_nettype wire

/* File: verif/sbc_synth_bit_rate_divisor_field_assertions.sv */
`default_nettype none
module sbc_checker (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire sbc_pkg::sbc_reg_req_s reg_req,
   input wire logic reg_req_valid,
   input wire logic [23:0] synth_word,
   input wire logic synth_word_load,
   input wire logic ref_external,
   input wire logic coarse_cal_run,
   input wire logic fine_cal_run,
   input wire sbc_pkg::sbc_radio_en_s radio_en,
   input wire logic general_pin_five,
   input wire logic bit_clock_pin
);
   logic [7:0] coarse_cnt;
   logic [7:0] fine_cnt;
   logic cal_seen;
   wire logic wr_any = reg_req_valid && reg_req.write;
   wire logic low_wr = wr_any && reg_req.addr == sbc_pkg::ADDR_CARRIER_LOW;
   wire logic ref_wr = wr_any && reg_req.addr == sbc_pkg::ADDR_REF_SELECT;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   // calibration lengths and first oscillator sign
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         coarse_cnt <= 8'h00;
         fine_cnt <= 8'h00;
         cal_seen <= 1'b0;
      end else begin
         coarse_cnt <= coarse_cal_run ? coarse_cnt + 8'h01 : 8'h00;
         fine_cnt <= fine_cal_run ? fine_cnt + 8'h01 : 8'h00;
         cal_seen <= cal_seen | coarse_cal_run;
      end
   end
   load_commit_a: assert property (low_wr |=> synth_word_load && synth_word[7:0] == $past(reg_req.data))
      else $error("low byte write not committed");
   word_hold_a: assert property (!synth_word_load |-> $stable(synth_word))
      else $error("carrier word moved without load");
   ref_select_a: assert property (ref_wr |-> ##2 ref_external == $past(reg_req.data[4], 2))
      else $error("reference select not applied");
   coarse_len_a: assert property ($fell(coarse_cal_run) |-> coarse_cnt == 8'h40)
      else $error("coarse calibration length wrong");
   fine_len_a: assert property ($fell(fine_cal_run) && radio_en.pll_enable |->
         fine_cnt == 8'h10)
      else $error("fine calibration length wrong");
   radio_excl_a: assert property (!(radio_en.tx_enable && radio_en.rx_enable))
      else $error("receiver and transmitter both on");
   reference_clock_output_wait_a: assert property (general_pin_five |=> cal_seen || coarse_cal_run)
      else $error("clock output before oscillator stable");
   bit_clock_a: assert property (bit_clock_pin |-> radio_en.tx_enable || radio_en.rx_enable)
      else $error("bit clock outside active state");
   cover property (low_wr);
   cover property ($fell(fine_cal_run));
   cover property (bit_clock_pin);
endmodule : sbc_checker
bind sbc_synth_bit_rate_divisor_field sbc_checker chk (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req),
   .reg_req_valid(reg_req_valid), .synth_word(synth_word), .synth_word_load(synth_word_load),
   .ref_external(ref_external), .coarse_cal_run(coarse_cal_run), .fine_cal_run(fine_cal_run),
   .radio_en(radio_en), .general_pin_five(general_pin_five), .bit_clock_pin(bit_clock_pin));
`default_nettype wire

/* File: verif/sbc_radio_model.sv */
`default_nettype none
module sbc_radio_model #(
   parameter int OSC_DELAY = 12,
   parameter int LOCK_DELAY = 6
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic fine_cal_run,
   input wire sbc_pkg::sbc_radio_en_s radio_en,
   output logic osc_stable_raw,
   output logic pll_lock_raw
);
   timeunit 1ns;
   timeprecision 1ps;
   int osc_cnt;
   int lock_cnt;
   // oscillator settles, loop locks after fine calibration
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_cnt <= 0;
         lock_cnt <= 0;
      end else begin
         osc_cnt <= (osc_cnt < OSC_DELAY) ? osc_cnt + 1 : osc_cnt;
         lock_cnt <= (radio_en.pll_enable && !fine_cal_run) ? lock_cnt + 1 : 0;
      end
   end
   assign osc_stable_raw = osc_cnt >= OSC_DELAY;
   assign pll_lock_raw = lock_cnt >= LOCK_DELAY;
endmodule : sbc_radio_model
`default_nettype wire

/* File: verif/sbc_synth_bit_rate_divisor_field_tb.sv */
`default_nettype none
module sbc_synth_bit_rate_divisor_field_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_b, reg_req_valid, osc_stable_raw, battery_below_raw, pll_lock_raw;
   logic serial_data_pin, synth_word_load, ref_external, coarse_cal_run, fine_cal_run;
   logic tx_data_bit, general_pin_five, bit_clock_pin, bit_m;
   logic [7:0] reg_rdata, hi, mid, lo;
   logic [3:0] general_pins;
   logic [23:0] synth_word, word_m;
   logic [6:0] rd_list[11] = '{7'h01, 7'h03, 7'h04, 7'h07, 7'h08, 7'h09, 7'h0C, 7'h25,
                               7'h26, 7'h59, 7'h7F};
   sbc_pkg::sbc_reg_req_s reg_req;
   sbc_pkg::sbc_radio_en_s radio_en;
   int miscompares = 0;
   int tests_run = 0;
   int mdl [int];
   int gaps [$];
   sbc_synth_bit_rate_divisor_field #(.OSC_SETTLE(20), .SYNTH_LOCK(20)) dut (.core_clk(core_clk),
      .rst_b(rst_b), .reg_req(reg_req), .reg_req_valid(reg_req_valid), .reg_rdata(reg_rdata),
      .osc_stable_raw(osc_stable_raw), .battery_below_raw(battery_below_raw),
      .pll_lock_raw(pll_lock_raw), .serial_data_pin(serial_data_pin), .synth_word(synth_word),
      .synth_word_load(synth_word_load), .ref_external(ref_external),
      .coarse_cal_run(coarse_cal_run), .fine_cal_run(fine_cal_run), .radio_en(radio_en),
      .tx_data_bit(tx_data_bit), .general_pin_five(general_pin_five),
      .general_pins(general_pins), .bit_clock_pin(bit_clock_pin));
   sbc_radio_model partner (.core_clk(core_clk), .rst_b(rst_b), .fine_cal_run(fine_cal_run),
      .radio_en(radio_en), .osc_stable_raw(osc_stable_raw), .pll_lock_raw(pll_lock_raw));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   // one register access; hold keeps the strobe up for a back-to-back follower
   task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] data,
                         input bit hold);
      reg_req = '{write: wr, addr: addr, data: data};
      reg_req_valid = 1'b1;
      cyc(1);
      if (!hold) reg_req_valid = 1'b0;
      if (wr) mdl[addr] = data;
      if (wr && addr == sbc_pkg::ADDR_CARRIER_LOW) word_m = {mdl[7][7:0], mdl[8][7:0], data};
   endtask : access
   task automatic close_out();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   initial begin
      repeat (3000) @(posedge core_clk);
      miscompares++;
      close_out();
   end
   initial begin
      rst_b = 1'b0;
      reg_req = '0;
      reg_req_valid = 1'b0;
      battery_below_raw = 1'b0;
      serial_data_pin = 1'b0;
      mdl = '{8'h01: 8'h84, 8'h03: 8'h1A, 8'h04: 8'h0B, 8'h07: 8'h6C, 8'h08: 8'h80,
              8'h09: 8'h00, 8'h0C: 8'h02, 8'h59: 8'h09};
      word_m = 24'h6C8000;
      void'($urandom(20));
      cyc(3);
      rst_b = 1'b1;
      chk_val(synth_word, word_m);
      chk_val(general_pin_five, 1'b0);
      for (int n = 0; n < 100 && general_pin_five !== 1'b1; n++) cyc(1);
      chk_val(general_pin_five, 1'b1);
      foreach (rd_list[i]) begin
         access(1'b0, rd_list[i], 8'h00, 1'b1);
         chk_val(reg_rdata, mdl.exists(rd_list[i]) ? mdl[rd_list[i]] : 0);
      end
      for (int i = 0; i < 3; i++) begin
         hi = 8'($urandom);
         mid = 8'($urandom);
         lo = 8'($urandom);
         access(1'b1, sbc_pkg::ADDR_CARRIER_HIGH, hi, 1'b1);
         access(1'b1, sbc_pkg::ADDR_CARRIER_MID, mid, 1'b1);
         chk_val(synth_word, word_m);
         access(1'b1, sbc_pkg::ADDR_CARRIER_LOW, lo, 1'b0);
         chk_val(synth_word, word_m);
         chk_val(synth_word_load, 1'b1);
         cyc(1);
         chk_val(synth_word_load, 1'b0);
      end
      access(1'b1, sbc_pkg::ADDR_REF_SELECT, 8'h19, 1'b0);
      cyc(1);
      chk_val(ref_external, 1'b1);
      access(1'b1, sbc_pkg::ADDR_RATE_HIGH, 8'h00, 1'b1);
      access(1'b1, sbc_pkg::ADDR_RATE_LOW, 8'h04, 1'b1);
      access(1'b1, sbc_pkg::ADDR_PIN_MAP, 8'h06, 1'b1);
      access(1'b1, sbc_pkg::ADDR_CONTROL, 8'hF4, 1'b0);
      for (int n = 0; n < 400 && radio_en.tx_enable !== 1'b1; n++) cyc(1);
      chk_val(radio_en, 3'b011);
      chk_val(general_pins[1], 1'b1);
      access(1'b0, sbc_pkg::ADDR_STATUS, 8'h00, 1'b0);
      chk_val(reg_rdata, 8'h07);
      for (int n = 0; n < 60 && gaps.size() < 3; n++) begin
         if (bit_clock_pin === 1'b1) gaps.push_back(n);
         cyc(1);
      end
      chk_val(gaps[1] - gaps[0], 4);
      chk_val(gaps[2] - gaps[1], 4);
      for (int i = 0; i < 2; i++) begin
         bit_m = (i == 0) ? 1'($urandom) : !bit_m;
         serial_data_pin = bit_m;
         cyc(20);
         chk_val(tx_data_bit, bit_m);
      end
      access(1'b1, sbc_pkg::ADDR_CONTROL, 8'hD4, 1'b0);
      serial_data_pin = !bit_m;
      cyc(8);
      chk_val(tx_data_bit, !bit_m);
      chk_val(bit_clock_pin, 1'b0);
      battery_below_raw = 1'b1;
      cyc(8);
      chk_val(general_pins[2], 1'b1);
      battery_below_raw = 1'b0;
      cyc(8);
      chk_val(general_pins[2], 1'b0);
      access(1'b1, sbc_pkg::ADDR_PIN_MAP2, 8'h07, 1'b0);
      cyc(3);
      chk_val(general_pin_five, 1'b0);
      access(1'b1, sbc_pkg::ADDR_PIN_MAP2, 8'h01, 1'b0);
      cyc(2);
      bit_m = general_pin_five;
      cyc(1);
      chk_val(general_pin_five, !bit_m);
      access(1'b1, sbc_pkg::ADDR_PIN_MAP2, 8'h00, 1'b1);
      access(1'b1, sbc_pkg::ADDR_CONTROL, 8'h80, 1'b0);
      cyc(6);
      chk_val(general_pin_five, 1'b0);
      chk_val(radio_en, 3'b000);
      close_out();
   end
endmodule : sbc_synth_bit_rate_divisor_field_tb
`default_nettype wire
